// *** hw/psbmrc_pkg.sv ***
// shared types and constants for the packed vector datapath
`default_nettype none
package psbmrc_pkg;
	localparam int          VEC_W           = 128;
	localparam int          GPR_W           = 64;
	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 32;
	localparam int          LOCK_W          = 4;
	// register map
	localparam logic [7:0]  CTRL_OFF        = 8'h00;
	localparam logic [7:0]  STATUS_OFF      = 8'h04;
	localparam logic [7:0]  OPCNT_OFF       = 8'h08;
	localparam int          CTRL_ALIGN_BIT  = 0;
	localparam int          CTRL_RM_LSB     = 1;
	localparam logic [2:0]  CTRL_RESET      = 3'h0;
	localparam int          STAT_INEX_BIT   = 0;
	localparam int          STAT_FAULT_BIT  = 1;
	localparam int          STAT_LOCK_LSB   = 4;
	// immediate fields of the rounding forms
	localparam int          IMM_GLOBAL_BIT  = 2;
	localparam int          IMM_NOINEX_BIT  = 3;
	// float layout
	localparam logic [63:0] ONE_D           = 64'h3ff0000000000000;
	localparam logic [63:0] ONE_S           = 64'h000000003f800000;
	localparam int          SIGN_D          = 63;
	localparam int          SIGN_S          = 31;
	localparam int          FRAC_D          = 52;
	localparam int          FRAC_S          = 23;
	localparam int          BIAS_D          = 1023;
	localparam int          BIAS_S          = 127;
	localparam logic [10:0] EXPMAX_D        = 11'h7ff;
	localparam logic [10:0] EXPMAX_S        = 11'h0ff;

	typedef enum logic [1:0] {RM_NEAREST, RM_DOWN, RM_UP, RM_TRUNC} psbmrc_rmode_t;

	typedef enum logic [5:0] {
		OP_NONE,
		BLEND_SINGLE_FLOAT_IMM, BLEND_DOUBLE_FLOAT_IMM, BLEND_SINGLE_FLOAT_VAR,
		BLEND_DOUBLE_FLOAT_VAR, BLEND_BYTE_VAR, BLEND_WORD_IMM,
		MIN_SIGNED_BYTE, MAX_SIGNED_BYTE, MIN_UNSIGNED_WORD, MAX_UNSIGNED_WORD,
		MIN_UNSIGNED_DWORD, MAX_UNSIGNED_DWORD, MIN_SIGNED_DWORD, MAX_SIGNED_DWORD,
		ROUND_PACKED_SINGLE, ROUND_PACKED_DOUBLE, ROUND_SCALAR_SINGLE, ROUND_SCALAR_DOUBLE,
		EXTRACT_SINGLE_FLOAT, INSERT_SINGLE_FLOAT,
		INSERT_INT_BYTE, INSERT_INT_DWORD, INSERT_INT_QWORD,
		EXTRACT_INT_BYTE, EXTRACT_INT_WORD, EXTRACT_INT_DWORD, EXTRACT_INT_QWORD,
		SIGN_WIDEN_BYTE_TO_WORD, ZERO_WIDEN_BYTE_TO_WORD,
		SIGN_WIDEN_BYTE_TO_DWORD, ZERO_WIDEN_BYTE_TO_DWORD,
		SIGN_WIDEN_WORD_TO_DWORD, ZERO_WIDEN_WORD_TO_DWORD,
		SIGN_WIDEN_BYTE_TO_QWORD, ZERO_WIDEN_BYTE_TO_QWORD,
		SIGN_WIDEN_WORD_TO_QWORD, ZERO_WIDEN_WORD_TO_QWORD,
		SIGN_WIDEN_DWORD_TO_QWORD, ZERO_WIDEN_DWORD_TO_QWORD
	} psbmrc_op_t;

	typedef struct packed {
		logic               valid;
		psbmrc_op_t         op;
		logic [7:0]         imm;
		logic [VEC_W-1:0]   dst;
		logic [VEC_W-1:0]   src;
		logic [VEC_W-1:0]   vecZero;
		logic [GPR_W-1:0]   gpr;
		logic [GPR_W-1:0]   mem;
		logic [3:0]         memAddr;
		logic               fromMem;
		logic               toMem;
	} psbmrc_req_t;

	typedef struct packed {
		logic [VEC_W-1:0]   vec;
		logic [GPR_W-1:0]   gpr;
		logic [GPR_W-1:0]   memData;
		logic [3:0]         memBytes;
		logic               wrVec;
		logic               wrGpr;
		logic               wrMem;
		logic               fault;
		logic               inexact;
	} psbmrc_rsp_t;
endpackage : psbmrc_pkg
`default_nettype wire

// *** hw/psbmrc_core.sv ***
// packed vector blend, min/max, round, insert/extract and widening datapath
`default_nettype none
module psbmrc_core (
	input  wire logic                               sys_clk,
	input  wire logic                               rst,
	input  wire psbmrc_pkg::psbmrc_req_t            req,
	output var  psbmrc_pkg::psbmrc_rsp_t            rsp,
	output logic                                    rspValid,
	input  wire logic [psbmrc_pkg::ADDR_W-1:0]      regAddr,
	input  wire logic [psbmrc_pkg::DATA_W-1:0]      regWdata,
	input  wire logic                               regWr,
	input  wire logic                               regRd,
	output logic [psbmrc_pkg::DATA_W-1:0]           regRdata,
	input  wire logic                               lockIssue,
	input  wire logic                               lockDone,
	input  wire logic                               ntLoadValid,
	output logic                                    ntLoadReady
);
	import psbmrc_pkg::*;

	// ----------------------------------------
	// element helpers
	// ----------------------------------------
	function automatic logic [63:0] getElem(input logic [127:0] v, input int lg,
			input int idx);
		logic [127:0] t;
		t = v >> (idx * (8 << lg));
		getElem = t[63:0] & ((lg == 3) ? ~64'h0 : ((64'h1 << (8 << lg)) - 64'h1));
	endfunction : getElem

	function automatic logic [127:0] putElem(input logic [127:0] v, input int lg,
			input int idx, input logic [63:0] x);
		logic [127:0] m;
		m = (lg == 3) ? {64'h0, ~64'h0} : ((128'h1 << (8 << lg)) - 128'h1);
		m = m << (idx * (8 << lg));
		putElem = (v & ~m) | (({64'h0, x} << (idx * (8 << lg))) & m);
	endfunction : putElem

	// one bit per element becomes one bit per byte
	function automatic logic [15:0] spread(input logic [15:0] sel, input int lg);
		spread = 16'h0;
		for (int i = 0; i < 16; i++) begin
			spread[i] = sel[i >> lg];
		end
	endfunction : spread

	function automatic logic [15:0] signBits(input logic [127:0] c, input int lg);
		signBits = 16'h0;
		for (int e = 0; e < 16; e++) begin
			if (e < (16 >> lg)) begin
				signBits[e] = c[(e + 1) * (8 << lg) - 1];
			end
		end
	endfunction : signBits

	function automatic logic [127:0] blend(input logic [127:0] d, input logic [127:0] s,
			input logic [15:0] m);
		for (int i = 0; i < 16; i++) begin
			blend[i*8 +: 8] = m[i] ? s[i*8 +: 8] : d[i*8 +: 8];
		end
	endfunction : blend

	function automatic logic [127:0] minMax(input logic [127:0] a, input logic [127:0] b,
			input int lg, input logic sgn, input logic mx);
		logic [63:0] x;
		logic [63:0] y;
		logic lt;
		minMax = a;
		for (int e = 0; e < 16; e++) begin
			if (e < (16 >> lg)) begin
				x = getElem(a, lg, e);
				y = getElem(b, lg, e);
				if (sgn) begin
					x = x ^ (64'h1 << ((8 << lg) - 1));
					y = y ^ (64'h1 << ((8 << lg) - 1));
				end
				lt = x < y;
				minMax = putElem(minMax, lg, e, (lt ^ mx) ? getElem(a, lg, e)
					: getElem(b, lg, e));
			end
		end
	endfunction : minMax

	// round to integral value; result in low bits, inexact on top
	function automatic logic [64:0] roundFp(input logic [63:0] v, input logic dbl,
			input logic [1:0] md);
		logic        sg;
		logic [10:0] ex;
		logic [63:0] sig;
		logic [63:0] msk;
		logic [63:0] frac;
		logic [63:0] half;
		logic [63:0] ns;
		logic [63:0] r;
		logic        up;
		logic        inx;
		int          ue;
		int          fw;
		int          fb;
		fw = dbl ? FRAC_D : FRAC_S;
		sg = dbl ? v[SIGN_D] : v[SIGN_S];
		ex = dbl ? v[62:52] : {3'h0, v[30:23]};
		sig = dbl ? {11'h0, 1'b1, v[51:0]} : {40'h0, 1'b1, v[22:0]};
		ue = int'(ex) - (dbl ? BIAS_D : BIAS_S);
		r = v;
		up = 1'b0;
		inx = 1'b0;
		if (ex == (dbl ? EXPMAX_D : EXPMAX_S) || ue >= fw) begin
			r = v;
		end else if (ue < 0) begin
			frac = sig & ((64'h1 << fw) - 64'h1);
			inx = (ex != 11'h0) || (frac != 64'h0);
			unique case (psbmrc_rmode_t'(md))
				RM_NEAREST: up = (ue == -1) && (frac != 64'h0);
				RM_DOWN:    up = sg && inx;
				RM_UP:      up = !sg && inx;
				RM_TRUNC:   up = 1'b0;
			endcase
			r = up ? (dbl ? ONE_D : ONE_S) : 64'h0;
			r[dbl ? SIGN_D : SIGN_S] = sg;
		end else begin
			fb = fw - ue;
			msk = (64'h1 << fb) - 64'h1;
			half = 64'h1 << (fb - 1);
			frac = sig & msk;
			inx = frac != 64'h0;
			unique case (psbmrc_rmode_t'(md))
				RM_NEAREST: up = (frac > half) || ((frac == half) && sig[fb]);
				RM_DOWN:    up = sg && inx;
				RM_UP:      up = !sg && inx;
				RM_TRUNC:   up = 1'b0;
			endcase
			ns = (sig & ~msk) + (up ? (msk + 64'h1) : 64'h0);
			// carry out of the significand bumps the exponent; low bits are then zero
			if (ns[fw + 1]) begin
				ex = ex + 11'h1;
			end
			r = dbl ? {sg, ex, ns[51:0]} : {32'h0, sg, ex[7:0], ns[22:0]};
		end
		roundFp = {inx, r};
	endfunction : roundFp

	function automatic logic [127:0] widen(input logic [127:0] s, input int sl,
			input int dl, input logic sgn);
		logic [63:0] t;
		widen = 128'h0;
		for (int e = 0; e < 8; e++) begin
			if (e < (16 >> dl)) begin
				t = getElem(s, sl, e);
				if (sgn && t[(8 << sl) - 1]) begin
					t = t | ~((64'h1 << (8 << sl)) - 64'h1);
				end
				widen = putElem(widen, dl, e, t);
			end
		end
	endfunction : widen

	function automatic logic misaligned(input logic [3:0] a, input logic [4:0] n);
		misaligned = (({1'b0, a} & (n - 5'h1)) != 5'h0);
	endfunction : misaligned

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [2:0]        ctrl_reg;
	logic              statInex_reg;
	logic              statFault_reg;
	logic [DATA_W-1:0] opCount_reg;
	logic [LOCK_W-1:0] lockCnt_reg;
	logic [DATA_W-1:0] rdData_reg;
	psbmrc_rsp_t       rsp_reg;
	psbmrc_rsp_t       rsp_next;
	logic              rspValid_reg;
	logic              alignOn;
	logic [1:0]        globalRm;

	assign alignOn  = ctrl_reg[CTRL_ALIGN_BIT];
	assign globalRm = ctrl_reg[CTRL_RM_LSB +: 2];

	// ----------------------------------------
	// datapath
	// ----------------------------------------
	always_comb begin
		logic [1:0]   md;
		logic [64:0]  rd;
		logic [127:0] cs;
		logic [63:0]  x;
		int           lg;
		int           sl;
		int           dl;
		logic [4:0]   nb;
		md = 2'h0;
		rd = 65'h0;
		cs = 128'h0;
		x = 64'h0;
		lg = 0;
		sl = 0;
		dl = 0;
		nb = 5'h0;
		rsp_next = '0;
		rsp_next.vec = req.dst;
		// the global mode is only read here, never written by an operation
		md = req.imm[IMM_GLOBAL_BIT] ? globalRm : req.imm[1:0];
		unique case (req.op)
			BLEND_SINGLE_FLOAT_IMM, BLEND_DOUBLE_FLOAT_IMM, BLEND_WORD_IMM: begin
				lg = (req.op == BLEND_SINGLE_FLOAT_IMM) ? 2
					: (req.op == BLEND_DOUBLE_FLOAT_IMM) ? 3 : 1;
				rsp_next.vec = blend(req.dst, req.src, spread({8'h0, req.imm}, lg));
				rsp_next.wrVec = 1'b1;
			end
			BLEND_SINGLE_FLOAT_VAR, BLEND_DOUBLE_FLOAT_VAR, BLEND_BYTE_VAR: begin
				lg = (req.op == BLEND_SINGLE_FLOAT_VAR) ? 2
					: (req.op == BLEND_DOUBLE_FLOAT_VAR) ? 3 : 0;
				rsp_next.vec = blend(req.dst, req.src,
					spread(signBits(req.vecZero, lg), lg));
				rsp_next.wrVec = 1'b1;
			end
			MIN_SIGNED_BYTE, MAX_SIGNED_BYTE: begin
				rsp_next.vec = minMax(req.dst, req.src, 0, 1'b1,
					req.op == MAX_SIGNED_BYTE);
				rsp_next.wrVec = 1'b1;
			end
			MIN_UNSIGNED_WORD, MAX_UNSIGNED_WORD: begin
				rsp_next.vec = minMax(req.dst, req.src, 1, 1'b0,
					req.op == MAX_UNSIGNED_WORD);
				rsp_next.wrVec = 1'b1;
			end
			MIN_UNSIGNED_DWORD, MAX_UNSIGNED_DWORD, MIN_SIGNED_DWORD, MAX_SIGNED_DWORD: begin
				rsp_next.vec = minMax(req.dst, req.src, 2,
					req.op inside {MIN_SIGNED_DWORD, MAX_SIGNED_DWORD},
					req.op inside {MAX_UNSIGNED_DWORD, MAX_SIGNED_DWORD});
				rsp_next.wrVec = 1'b1;
			end
			ROUND_PACKED_SINGLE, ROUND_SCALAR_SINGLE: begin
				// scalar forms touch element 0 and keep the rest of the destination
				for (int e = 0; e < 4; e++) begin
					if (e == 0 || req.op == ROUND_PACKED_SINGLE) begin
						rd = roundFp({32'h0, req.src[e*32 +: 32]}, 1'b0, md);
						rsp_next.vec[e*32 +: 32] = rd[31:0];
						rsp_next.inexact = rsp_next.inexact | rd[64];
					end
				end
				rsp_next.wrVec = 1'b1;
			end
			ROUND_PACKED_DOUBLE, ROUND_SCALAR_DOUBLE: begin
				for (int e = 0; e < 2; e++) begin
					if (e == 0 || req.op == ROUND_PACKED_DOUBLE) begin
						rd = roundFp(req.src[e*64 +: 64], 1'b1, md);
						rsp_next.vec[e*64 +: 64] = rd[63:0];
						rsp_next.inexact = rsp_next.inexact | rd[64];
					end
				end
				rsp_next.wrVec = 1'b1;
			end
			EXTRACT_SINGLE_FLOAT, EXTRACT_INT_BYTE, EXTRACT_INT_WORD, EXTRACT_INT_DWORD,
			EXTRACT_INT_QWORD: begin
				lg = (req.op == EXTRACT_INT_BYTE) ? 0 : (req.op == EXTRACT_INT_WORD) ? 1
					: (req.op == EXTRACT_INT_QWORD) ? 3 : 2;
				x = getElem(req.src, lg, int'(req.imm[3:0]) & ((16 >> lg) - 1));
				nb = 5'(1 << lg);
				rsp_next.gpr = x;
				rsp_next.memData = x;
				rsp_next.memBytes = nb[3:0];
				rsp_next.wrGpr = !req.toMem;
				rsp_next.wrMem = req.toMem;
				rsp_next.fault = req.toMem && alignOn && misaligned(req.memAddr, nb);
			end
			INSERT_SINGLE_FLOAT: begin
				x = req.fromMem ? {32'h0, req.mem[31:0]}
					: getElem(req.src, 2, int'(req.imm[7:6]));
				cs = putElem(req.dst, 2, int'(req.imm[5:4]), x);
				for (int e = 0; e < 4; e++) begin
					if (req.imm[e]) begin
						cs[e*32 +: 32] = 32'h0;
					end
				end
				rsp_next.vec = cs;
				rsp_next.wrVec = 1'b1;
				rsp_next.fault = req.fromMem && alignOn && misaligned(req.memAddr, 5'h4);
			end
			INSERT_INT_BYTE, INSERT_INT_DWORD, INSERT_INT_QWORD: begin
				lg = (req.op == INSERT_INT_BYTE) ? 0 : (req.op == INSERT_INT_DWORD) ? 2 : 3;
				x = req.fromMem ? req.mem : req.gpr;
				rsp_next.vec = putElem(req.dst, lg,
					int'(req.imm[3:0]) & ((16 >> lg) - 1), x);
				rsp_next.wrVec = 1'b1;
				nb = 5'(1 << lg);
				rsp_next.fault = req.fromMem && alignOn && misaligned(req.memAddr, nb);
			end
			SIGN_WIDEN_BYTE_TO_WORD, ZERO_WIDEN_BYTE_TO_WORD, SIGN_WIDEN_BYTE_TO_DWORD,
			ZERO_WIDEN_BYTE_TO_DWORD, SIGN_WIDEN_WORD_TO_DWORD, ZERO_WIDEN_WORD_TO_DWORD,
			SIGN_WIDEN_BYTE_TO_QWORD, ZERO_WIDEN_BYTE_TO_QWORD, SIGN_WIDEN_WORD_TO_QWORD,
			ZERO_WIDEN_WORD_TO_QWORD, SIGN_WIDEN_DWORD_TO_QWORD,
			ZERO_WIDEN_DWORD_TO_QWORD: begin
				sl = (req.op inside {SIGN_WIDEN_WORD_TO_DWORD, ZERO_WIDEN_WORD_TO_DWORD,
					SIGN_WIDEN_WORD_TO_QWORD, ZERO_WIDEN_WORD_TO_QWORD}) ? 1
					: (req.op inside {SIGN_WIDEN_DWORD_TO_QWORD,
					ZERO_WIDEN_DWORD_TO_QWORD}) ? 2 : 0;
				dl = (req.op inside {SIGN_WIDEN_BYTE_TO_WORD, ZERO_WIDEN_BYTE_TO_WORD}) ? 1
					: (req.op inside {SIGN_WIDEN_BYTE_TO_DWORD, ZERO_WIDEN_BYTE_TO_DWORD,
					SIGN_WIDEN_WORD_TO_DWORD, ZERO_WIDEN_WORD_TO_DWORD}) ? 2 : 3;
				nb = 5'((16 >> dl) << sl);
				cs = req.fromMem ? {64'h0, req.mem} : req.src;
				rsp_next.vec = widen(cs, sl, dl,
					req.op inside {SIGN_WIDEN_BYTE_TO_WORD, SIGN_WIDEN_BYTE_TO_DWORD,
					SIGN_WIDEN_WORD_TO_DWORD, SIGN_WIDEN_BYTE_TO_QWORD,
					SIGN_WIDEN_WORD_TO_QWORD, SIGN_WIDEN_DWORD_TO_QWORD});
				rsp_next.wrVec = 1'b1;
				rsp_next.fault = req.fromMem && alignOn && misaligned(req.memAddr, nb);
			end
			default: begin
				rsp_next.vec = req.dst;
			end
		endcase
		// a faulting operation commits nothing
		if (rsp_next.fault) begin
			rsp_next.wrVec = 1'b0;
			rsp_next.wrGpr = 1'b0;
			rsp_next.wrMem = 1'b0;
			rsp_next.vec = req.dst;
		end
		rsp_next.inexact = rsp_next.inexact && !req.imm[IMM_NOINEX_BIT];
	end

	// ----------------------------------------
	// result stage
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rsp_reg <= '0;
			rspValid_reg <= 1'b0;
		end else begin
			rspValid_reg <= req.valid && req.op != OP_NONE;
			// an empty request leaves the last answer standing
			if (req.valid && req.op != OP_NONE) begin
				rsp_reg <= rsp_next;
			end
		end
	end

	assign rsp      = rsp_reg;
	assign rspValid = rspValid_reg;

	// ----------------------------------------
	// streaming load ordering
	// ----------------------------------------
	// locked operations are counted from issue to completion; a wrap past the
	// counter width is not guarded, the core never has that many in flight
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			lockCnt_reg <= '0;
		end else if (lockIssue && !lockDone) begin
			lockCnt_reg <= lockCnt_reg + LOCK_W'(1);
		end else if (lockDone && !lockIssue && lockCnt_reg != '0) begin
			lockCnt_reg <= lockCnt_reg - LOCK_W'(1);
		end
	end

	// only locks hold streaming loads back; other ordering is left to fences
	assign ntLoadReady = (lockCnt_reg == '0) && !lockIssue;

	// ----------------------------------------
	// software registers
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl_reg <= CTRL_RESET;
		end else if (regWr && regAddr == CTRL_OFF) begin
			ctrl_reg <= regWdata[2:0];
		end
	end

	// sticky flags: write one to clear, a new event in the same cycle wins
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			statInex_reg <= 1'b0;
			statFault_reg <= 1'b0;
		end else begin
			if (rspValid_reg && rsp_reg.inexact) begin
				statInex_reg <= 1'b1;
			end else if (regWr && regAddr == STATUS_OFF && regWdata[STAT_INEX_BIT]) begin
				statInex_reg <= 1'b0;
			end
			if (rspValid_reg && rsp_reg.fault) begin
				statFault_reg <= 1'b1;
			end else if (regWr && regAddr == STATUS_OFF && regWdata[STAT_FAULT_BIT]) begin
				statFault_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			opCount_reg <= '0;
		end else if (rspValid_reg) begin
			opCount_reg <= opCount_reg + DATA_W'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rdData_reg <= '0;
		end else if (regRd) begin
			unique case (regAddr)
				CTRL_OFF:   rdData_reg <= {29'h0, ctrl_reg};
				STATUS_OFF: rdData_reg <= {24'h0, lockCnt_reg, 2'h0, statFault_reg,
					statInex_reg};
				OPCNT_OFF:  rdData_reg <= opCount_reg;
				default:    rdData_reg <= '0;
			endcase
		end else begin
			rdData_reg <= '0;
		end
	end

	assign regRdata = rdData_reg;
endmodule : psbmrc_core
`default_nettype wire

// *** bench/psbmrc_props.sv ***
// concurrent checks on the datapath ports
`default_nettype none
module psbmrc_props (
	input wire logic                    sys_clk,
	input wire logic                    rst,
	input wire psbmrc_pkg::psbmrc_req_t req,
	input wire psbmrc_pkg::psbmrc_rsp_t rsp,
	input wire logic                    rspValid,
	input wire logic                    regRd,
	input wire logic [31:0]             regRdata,
	input wire logic                    lockIssue,
	input wire logic                    lockDone,
	input wire logic                    ntLoadReady
);
	timeunit 1ns;
	timeprecision 1ps;
	import psbmrc_pkg::*;
	// ----
	// helpers and properties
	// ----
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic         acc;
	logic [127:0] bmix;
	assign acc = req.valid && req.op != OP_NONE;
	// per-byte reference of the variable byte blend
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			bmix[i*8 +: 8] = req.vecZero[i*8+7] ? req.src[i*8 +: 8] : req.dst[i*8 +: 8];
		end
	end
	sequence s_lock; lockIssue && !lockDone; endsequence
	sequence s_held; !lockDone [*2]; endsequence
	property p_answer; acc |=> rspValid; endproperty
	property p_quiet; !acc |=> !rspValid && $stable(rsp); endproperty
	property p_rd_idle; !regRd |=> regRdata == 32'h0; endproperty
	property p_lock; lockIssue |-> !ntLoadReady; endproperty
	property p_lock_held; s_lock ##1 s_held |-> !ntLoadReady; endproperty
	property p_fault; rspValid && rsp.fault |-> !(rsp.wrVec || rsp.wrGpr || rsp.wrMem); endproperty
	property p_noalign;
		acc && !req.fromMem && !req.toMem &&
		req.op inside {[EXTRACT_SINGLE_FLOAT:EXTRACT_INT_QWORD]} |=> !rsp.fault;
	endproperty
	property p_widen;
		acc && req.op >= SIGN_WIDEN_BYTE_TO_WORD |=>
		rsp.fault || (rsp.wrVec && !rsp.wrGpr && !rsp.wrMem);
	endproperty
	property p_blend; acc && req.op == BLEND_BYTE_VAR |=> rsp.vec == $past(bmix); endproperty
	a_answer: assert property (p_answer) else $error("no answer after request");
	a_quiet: assert property (p_quiet) else $error("response moved without request");
	a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
	a_lock: assert property (p_lock) else $error("load ready beside lock");
	a_lock_held: assert property (p_lock_held) else $error("load passed lock");
	a_fault: assert property (p_fault) else $error("fault with commit");
	a_noalign: assert property (p_noalign) else $error("register move faulted");
	a_widen: assert property (p_widen) else $error("widen not to vector");
	a_blend: assert property (p_blend) else $error("byte blend wrong");
endmodule : psbmrc_props
bind psbmrc_core psbmrc_props i_psbmrc_props (.sys_clk(sys_clk), .rst(rst), .req(req),
	.rsp(rsp), .rspValid(rspValid), .regRd(regRd), .regRdata(regRdata),
	.lockIssue(lockIssue), .lockDone(lockDone), .ntLoadReady(ntLoadReady));
`default_nettype wire

// *** bench/psbmrc_lock_model.sv ***
// issuing side model: a locked operation with a younger streaming load behind it
`default_nettype none
module psbmrc_lock_model (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       go,
	input  wire logic [3:0] len,
	output logic            lockIssue,
	output logic            lockDone,
	output logic            ntLoadValid
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// lock lifetime
	// ----
	logic [3:0] cnt_reg;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cnt_reg <= 4'h0;
			lockIssue <= 1'b0;
			lockDone <= 1'b0;
		end else begin
			lockIssue <= go;
			lockDone <= cnt_reg == 4'h1;
			cnt_reg <= go ? len : cnt_reg - 4'(cnt_reg != 4'h0);
		end
	end
	// the load asks from lock issue until the lock count runs out; only the lock holds it back
	assign ntLoadValid = lockIssue || cnt_reg != 4'h0;
endmodule : psbmrc_lock_model
`default_nettype wire

// *** bench/psbmrc_core_test.sv ***
// self-checking bench for the packed vector datapath
`default_nettype none
module psbmrc_core_test;
	timeunit 1ns;
	timeprecision 1ps;
	import psbmrc_pkg::*;
	logic              sys_clk = 1'b0;
	logic              rst = 1'b1;
	psbmrc_req_t       req = '0;
	psbmrc_rsp_t       rsp;
	logic              rspValid;
	logic [ADDR_W-1:0] regAddr = '0;
	logic [DATA_W-1:0] regWdata = '0;
	logic              regWr = 1'b0;
	logic              regRd = 1'b0;
	logic [DATA_W-1:0] regRdata;
	logic              lockIssue;
	logic              lockDone;
	logic              ntLoadValid;
	logic              ntLoadReady;
	logic              lkGo = 1'b0;
	int                mismatches = 0;
	int                n_compared = 0;
	int                cyc = 0;
	always #10 sys_clk = ~sys_clk;
	psbmrc_core i_psbmrc_core (.sys_clk(sys_clk), .rst(rst), .req(req), .rsp(rsp),
		.rspValid(rspValid), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .lockIssue(lockIssue), .lockDone(lockDone),
		.ntLoadValid(ntLoadValid), .ntLoadReady(ntLoadReady));
	psbmrc_lock_model i_psbmrc_lock_model (.sys_clk(sys_clk), .rst(rst), .go(lkGo),
		.len(4'h6), .lockIssue(lockIssue), .lockDone(lockDone), .ntLoadValid(ntLoadValid));
	// ----
	// tasks
	// ----
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : print_verdict
	task automatic cmp_val(input logic [127:0] exp, input logic [127:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : cmp_val
	task automatic go(input psbmrc_req_t r);
		r.valid = 1'b1;
		@(posedge sys_clk) req <= r;
		@(posedge sys_clk) req.valid <= 1'b0;
		#1 cmp_val(1, rspValid);
	endtask : go
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk) begin
			regAddr <= a;
			regWdata <= d;
			regWr <= 1'b1;
		end
		@(posedge sys_clk) regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk) begin
			regAddr <= a;
			regRd <= 1'b1;
		end
		@(posedge sys_clk) regRd <= 1'b0;
		#1 d = regRdata;
	endtask : rd
	task automatic t_blend();
		psbmrc_req_t r;
		r = '0;
		r.op = BLEND_BYTE_VAR;
		r.dst = {4{32'h11111111}};
		r.src = {4{32'h22222222}};
		r.vecZero = {8{16'h807f}};
		go(r);
		cmp_val({8{16'h2211}}, rsp.vec);
		r.op = BLEND_SINGLE_FLOAT_IMM;
		r.imm = 8'h05;
		r.vecZero = '1;
		go(r);
		cmp_val({2{64'h11111111_22222222}}, rsp.vec);
	endtask : t_blend
	task automatic t_minmax();
		psbmrc_req_t r;
		r = '0;
		r.dst = '1;
		r.src = {16{8'h01}};
		for (int k = 0; k < 8; k++) begin
			r.op = psbmrc_op_t'(MIN_SIGNED_BYTE + k);
			go(r);
			cmp_val(((8'h69 >> k) & 8'h1) != 0 ? r.dst : r.src, rsp.vec);
		end
	endtask : t_minmax
	task automatic t_round();
		psbmrc_req_t r;
		logic [63:0] two;
		logic [63:0] thr;
		logic [31:0] d;
		two = 64'h4000000000000000;
		thr = 64'h4008000000000000;
		r = '0;
		r.op = ROUND_SCALAR_DOUBLE;
		r.dst = {64'h0123456789abcdef, 64'h0};
		r.src = {64'h0, 64'h4006000000000000};
		for (int m = 0; m < 4; m++) begin
			r.imm = 8'(m);
			go(r);
			cmp_val({r.dst[127:64], m[0] ? two : thr}, rsp.vec);
			cmp_val(1, rsp.inexact);
		end
		r.imm = 8'h09;
		go(r);
		cmp_val(0, rsp.inexact);
		wr(CTRL_OFF, 32'h4);
		r.imm = 8'h05;
		go(r);
		cmp_val({r.dst[127:64], thr}, rsp.vec);
		rd(CTRL_OFF, d);
		cmp_val(32'h4, d);
		wr(CTRL_OFF, 32'h0);
		r.op = ROUND_PACKED_SINGLE;
		r.imm = 8'h03;
		r.src = {4{32'h3fc00000}};
		go(r);
		cmp_val({4{32'h3f800000}}, rsp.vec);
	endtask : t_round
	task automatic t_insext();
		psbmrc_req_t r;
		r = '0;
		r.src = {32'h44444444, 32'h33333333, 32'h22222222, 32'h11111111};
		r.dst = {4{32'haaaaaaaa}};
		r.op = EXTRACT_INT_DWORD;
		r.imm = 8'h02;
		go(r);
		cmp_val({rsp.wrGpr, rsp.gpr}, {1'b1, 64'h33333333});
		r.op = INSERT_SINGLE_FLOAT;
		r.imm = 8'h71;
		go(r);
		cmp_val({32'h22222222, 64'haaaaaaaa_aaaaaaaa, 32'h0}, rsp.vec);
		r.op = INSERT_INT_BYTE;
		r.imm = 8'h0f;
		r.gpr = 64'h5a;
		go(r);
		cmp_val({8'h5a, {15{8'haa}}}, rsp.vec);
		r.op = EXTRACT_SINGLE_FLOAT;
		r.imm = 8'h01;
		r.toMem = 1'b1;
		r.memAddr = 4'h3;
		go(r);
		cmp_val({2'b01, 4'h4, 64'h22222222},
			{rsp.fault, rsp.wrMem, rsp.memBytes, rsp.memData});
	endtask : t_insext
	task automatic t_widen();
		psbmrc_req_t r;
		logic [31:0] d;
		r = '0;
		r.fromMem = 1'b1;
		r.mem = 64'h807f01ff_00000002;
		r.op = SIGN_WIDEN_BYTE_TO_WORD;
		go(r);
		cmp_val({64'hff80007f0001ffff, 64'h2}, rsp.vec);
		r.op = ZERO_WIDEN_BYTE_TO_WORD;
		go(r);
		cmp_val({64'h0080007f000100ff, 64'h2}, rsp.vec);
		r.op = SIGN_WIDEN_DWORD_TO_QWORD;
		go(r);
		cmp_val({64'hffffffff807f01ff, 64'h2}, rsp.vec);
		r.op = ZERO_WIDEN_DWORD_TO_QWORD;
		r.fromMem = 1'b0;
		r.src = {64'h0, r.mem};
		r.mem = '0;
		go(r);
		cmp_val({64'h807f01ff, 64'h2}, rsp.vec);
		wr(CTRL_OFF, 32'h1);
		r.fromMem = 1'b1;
		r.op = SIGN_WIDEN_BYTE_TO_WORD;
		r.memAddr = 4'h4;
		go(r);
		cmp_val({rsp.fault, rsp.vec}, {1'b1, r.dst});
		r.memAddr = 4'h8;
		go(r);
		cmp_val(0, rsp.fault);
		r.op = SIGN_WIDEN_BYTE_TO_QWORD;
		r.memAddr = 4'h2;
		go(r);
		cmp_val(0, rsp.fault);
		rd(STATUS_OFF, d);
		cmp_val(2'h3, d[STAT_FAULT_BIT:STAT_INEX_BIT]);
		wr(STATUS_OFF, 32'h3);
		rd(STATUS_OFF, d);
		cmp_val(0, d);
		wr(8'hfc, 32'hffffffff);
		wr(CTRL_OFF, 32'h0);
		rd(8'hfc, d);
		cmp_val(0, d);
	endtask : t_widen
	task automatic t_lock();
		logic [31:0] d;
		// 28 operations were issued by the scenarios before this one
		rd(OPCNT_OFF, d);
		cmp_val(32'h1c, d);
		@(posedge sys_clk) lkGo <= 1'b1;
		@(posedge sys_clk) lkGo <= 1'b0;
		#1 cmp_val(0, ntLoadReady);
		rd(STATUS_OFF, d);
		cmp_val({1'b0, 4'h1}, {ntLoadReady, d[7:4]});
		repeat (8) @(posedge sys_clk);
		#1 cmp_val(1, ntLoadReady);
	endtask : t_lock
	// ----
	// run
	// ----
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			mismatches++;
			print_verdict();
		end
	end
	initial begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		t_blend();
		t_minmax();
		t_round();
		t_insext();
		t_widen();
		t_lock();
		print_verdict();
	end
endmodule : psbmrc_core_test
`default_nettype wire
